// ---- hdl/sgp_pkg.sv ----
// sgp_pkg: constants and types for the switch global power control bank
package sgp_pkg;

   // ****************************************************************
   // register offsets
   // ****************************************************************
   localparam logic [7:0] SGP_OFS_MGMT_TRAILER = 8'h0c;
   localparam logic [7:0] SGP_OFS_FACTORY_TEST = 8'h0d;
   localparam logic [7:0] SGP_OFS_POWER_DOWN   = 8'h0e;
   localparam logic [7:0] SGP_OFS_SLEEP_DELAY  = 8'h0f;

   // ****************************************************************
   // field positions and reset values
   // ****************************************************************
   localparam int         SGP_MCS_LSB        = 4;
   localparam int         SGP_TRAILER_BIT    = 1;
   localparam int         SGP_PAUSE_BIT      = 0;
   localparam int         SGP_PLL_PD_BIT     = 5;
   localparam int         SGP_PMODE_LSB      = 3;
   localparam logic [1:0] SGP_RSVD_HI_VAL    = 2'h1;
   localparam logic [1:0] SGP_RSVD_MID_VAL   = 2'h1;
   localparam logic [7:0] SGP_FACTORY_VAL    = 8'h00;
   localparam logic [7:0] SGP_SLEEP_DELAY_RST = 8'h50;
   localparam logic [2:0] SGP_UPLINK_PORT    = 3'h5;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int SGP_CLK_HZ        = 10_000_000;
   localparam int SGP_SLEEP_UNIT_MS = 20;
   localparam int SGP_UNIT_CYCLES   = SGP_CLK_HZ / 1000 * SGP_SLEEP_UNIT_MS;
   localparam int SGP_PRESCALE_W    = 18;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [1:0] {
      SGP_MCLK_41M  = 2'h0,
      SGP_MCLK_83M  = 2'h1,
      SGP_MCLK_125M = 2'h2,
      SGP_MCLK_RSVD = 2'h3
   } sgp_mgmt_clk_t;

   typedef enum logic [1:0] {
      SGP_PM_NORMAL_POWER_STATE   = 2'h0,
      SGP_PM_ENERGY_DETECT_STATE  = 2'h1,
      SGP_PM_SOFT_POWER_DOWN_STATE = 2'h2,
      SGP_PM_RSVD                 = 2'h3
   } sgp_power_mode_t;

   typedef enum logic [1:0] {
      SGP_SL_AWAKE    = 2'h0,
      SGP_SL_COUNTING = 2'h1,
      SGP_SL_ASLEEP   = 2'h3
   } sgp_sleep_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } sgp_reg_req_t;

endpackage

// ---- hdl/sgp_regs.sv ----
// sgp_regs: global management, trailer and power control register bank
// ****************************************************************
// Summary of operation
// RQ1 - clock select 00 runs management logic at 41.67 MHz
// RQ2 - clock select resets to 01, the 83.33 MHz setting
// RQ3 - clock select 10 gives 125 MHz; software never writes 11
// RQ4 - trailer bit set inserts one byte before the FCS
// RQ5 - trailer insertion only on frames leaving uplink port 5
// RQ6 - pause-pass bit 1 forwards 802.3x pause frames, 0 drops them
// RQ7 - PLL power-down bit acts only in energy-detect mode, resets 0
// RQ8 - power mode: 00 normal, 01 energy-detect, 10 soft power-down
// RQ9 - reading the power mode field returns it and clears it
// RQ10 - low power only after sleep-delay 20 ms units without energy
// RQ11 - sleep delay resets to 80 units, 1.6 seconds
// RQ12 - factory test register at 0x0d reads zero, read-only
// RQ13 - energy seen during the countdown restarts it from zero
// ****************************************************************
`timescale 1ns/1ns
`default_nettype none

module sgp_regs
   import sgp_pkg::*;
#(
   parameter int UNIT_CYCLES = SGP_UNIT_CYCLES
) (
   input  wire logic            i_clk,
   input  wire logic            i_reset,
   input  wire sgp_reg_req_t    i_req,
   output logic [7:0]           o_reg_rdata,
   output logic                 o_reg_rvalid,
   input  wire logic [2:0]      i_egress_port,
   input  wire logic            i_pause_frame,
   input  wire logic            i_energy_detected,
   output sgp_mgmt_clk_t        o_mgmt_clk_sel,
   output logic                 o_trailer_insert,
   output logic                 o_pause_drop,
   output sgp_power_mode_t      o_power_mode,
   output logic                 o_pll_power_down,
   output logic                 o_low_power
);

   // ****************************************************************
   // register state
   // ****************************************************************
   sgp_mgmt_clk_t   mclk_q,    mclk_d;
   logic            trail_q,   trail_d;
   logic            pass_q,    pass_d;
   logic            pllpd_q,   pllpd_d;
   sgp_power_mode_t pmode_q,   pmode_d;
   logic [7:0]      delay_q,   delay_d;
   logic [7:0]      rdata_q,   rdata_d;
   logic            rvalid_q,  rvalid_d;

   logic wr_mt;
   logic wr_pd;
   logic wr_sd;
   logic rd_pd;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   always_comb begin
      wr_mt = i_req.wr && hit(i_req.addr, SGP_OFS_MGMT_TRAILER);
      wr_pd = i_req.wr && hit(i_req.addr, SGP_OFS_POWER_DOWN);
      wr_sd = i_req.wr && hit(i_req.addr, SGP_OFS_SLEEP_DELAY);
      rd_pd = i_req.rd && hit(i_req.addr, SGP_OFS_POWER_DOWN);
   end

   always_comb begin
      mclk_d   = mclk_q;
      trail_d  = trail_q;
      pass_d   = pass_q;
      pllpd_d  = pllpd_q;
      pmode_d  = pmode_q;
      delay_d  = delay_q;
      rvalid_d = i_req.rd;
      rdata_d  = rdata_q;
      if (wr_mt) begin
         // see RQ1, see RQ2, see RQ3
         mclk_d  = sgp_mgmt_clk_t'(i_req.wdata[SGP_MCS_LSB +: 2]);
         trail_d = i_req.wdata[SGP_TRAILER_BIT];
         pass_d  = i_req.wdata[SGP_PAUSE_BIT];
      end
      if (rd_pd) begin
         pmode_d = SGP_PM_NORMAL_POWER_STATE;                // see RQ9
      end
      if (wr_pd) begin
         pllpd_d = i_req.wdata[SGP_PLL_PD_BIT];
         pmode_d = sgp_power_mode_t'(i_req.wdata[SGP_PMODE_LSB +: 2]);
      end
      if (wr_sd) begin
         delay_d = i_req.wdata;
      end
      if (i_req.rd) begin
         unique case (i_req.addr)
            SGP_OFS_MGMT_TRAILER:
               rdata_d = {SGP_RSVD_HI_VAL, mclk_q, SGP_RSVD_MID_VAL,
                          trail_q, pass_q};
            SGP_OFS_FACTORY_TEST:
               rdata_d = SGP_FACTORY_VAL;                    // see RQ12
            SGP_OFS_POWER_DOWN:
               rdata_d = {2'h0, pllpd_q, pmode_q, 3'h0};     // see RQ9
            SGP_OFS_SLEEP_DELAY:
               rdata_d = delay_q;
            default:
               rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         mclk_q   <= SGP_MCLK_83M;                           // see RQ2
         trail_q  <= 1'b0;
         pass_q   <= 1'b0;
         pllpd_q  <= 1'b0;                                   // see RQ7
         pmode_q  <= SGP_PM_NORMAL_POWER_STATE;              // see RQ8
         delay_q  <= SGP_SLEEP_DELAY_RST;                    // see RQ11
         rdata_q  <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         mclk_q   <= mclk_d;
         trail_q  <= trail_d;
         pass_q   <= pass_d;
         pllpd_q  <= pllpd_d;
         pmode_q  <= pmode_d;
         delay_q  <= delay_d;
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // ****************************************************************
   // energy input synchroniser
   // ****************************************************************
   logic energy_s1_q;
   logic energy_s2_q;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         energy_s1_q <= 1'b0;
         energy_s2_q <= 1'b0;
      end else begin
         energy_s1_q <= i_energy_detected;
         energy_s2_q <= energy_s1_q;
      end
   end

   // ****************************************************************
   // sleep countdown in 20 ms units
   // ****************************************************************
   sgp_sleep_state_t          sl_q,    sl_d;
   logic [SGP_PRESCALE_W-1:0] pre_q,   pre_d;
   logic [7:0]                units_q, units_d;
   logic                      energy_detect_power_down_mode;
   logic                      unit_tick;

   always_comb begin
      energy_detect_power_down_mode = (pmode_q == SGP_PM_ENERGY_DETECT_STATE);
      unit_tick = (pre_q == SGP_PRESCALE_W'(UNIT_CYCLES - 1));
      sl_d      = sl_q;
      pre_d     = pre_q;
      units_d   = units_q;
      if (!energy_detect_power_down_mode || energy_s2_q) begin
         // see RQ13
         sl_d    = SGP_SL_AWAKE;
         pre_d   = '0;
         units_d = 8'h00;
      end else begin
         unique case (sl_q)
            SGP_SL_AWAKE: begin
               sl_d    = SGP_SL_COUNTING;
               pre_d   = '0;
               units_d = 8'h00;
            end
            SGP_SL_COUNTING: begin
               if (units_q >= delay_q) begin
                  sl_d = SGP_SL_ASLEEP;                      // see RQ10
               end else if (unit_tick) begin
                  pre_d   = '0;
                  units_d = units_q + 8'h01;
               end else begin
                  pre_d = pre_q + SGP_PRESCALE_W'(1);
               end
            end
            SGP_SL_ASLEEP: begin
               sl_d = SGP_SL_ASLEEP;
            end
            default: begin
               sl_d = SGP_SL_AWAKE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         sl_q    <= SGP_SL_AWAKE;
         pre_q   <= '0;
         units_q <= 8'h00;
      end else begin
         sl_q    <= sl_d;
         pre_q   <= pre_d;
         units_q <= units_d;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   always_comb begin
      o_reg_rdata      = rdata_q;
      o_reg_rvalid     = rvalid_q;
      o_mgmt_clk_sel   = mclk_q;                             // see RQ1
      // see RQ4, see RQ5
      o_trailer_insert = trail_q && (i_egress_port == SGP_UPLINK_PORT);
      o_pause_drop     = i_pause_frame && !pass_q;           // see RQ6
      o_power_mode     = pmode_q;                            // see RQ8
      o_pll_power_down = pllpd_q && energy_detect_power_down_mode;               // see RQ7
      o_low_power      = (sl_q == SGP_SL_ASLEEP);            // see RQ10
   end

endmodule

`default_nettype wire

// ---- test/sgp_regs_chk.sv ----
// sgp_regs_chk: port assertions for the register bank
`timescale 1ns/1ns
`default_nettype none
module sgp_regs_chk
   import sgp_pkg::*;
#(parameter int UNIT_CYCLES = 4)
(
   input wire logic            i_clk,
   input wire logic            i_reset,
   input wire sgp_reg_req_t    i_req,
   input wire logic [7:0]      o_reg_rdata,
   input wire logic            o_reg_rvalid,
   input wire logic [2:0]      i_egress_port,
   input wire logic            i_pause_frame,
   input wire logic            i_energy_detected,
   input wire sgp_mgmt_clk_t   o_mgmt_clk_sel,
   input wire logic            o_trailer_insert,
   input wire logic            o_pause_drop,
   input wire sgp_power_mode_t o_power_mode,
   input wire logic            o_pll_power_down,
   input wire logic            o_low_power
);
   logic [7:0]  dly_q, dly_d;
   logic [15:0] qt_q, qt_d;
   logic        trl_q, trl_d;
   logic        pas_q, pas_d;
   // shadow sleep delay, trailer and pass bits, raw quiet-cycle count
   always_comb begin
      dly_d = dly_q;
      trl_d = trl_q;
      pas_d = pas_q;
      qt_d  = qt_q + 16'h1;
      if (i_req.wr && i_req.addr == SGP_OFS_SLEEP_DELAY)
         dly_d = i_req.wdata;
      if (i_req.wr && i_req.addr == SGP_OFS_MGMT_TRAILER) begin
         trl_d = i_req.wdata[SGP_TRAILER_BIT];
         pas_d = i_req.wdata[SGP_PAUSE_BIT];
      end
      if (o_power_mode != 2'h1 || i_energy_detected || i_reset)
         qt_d = 16'h0;
      if (i_reset) begin
         dly_d = SGP_SLEEP_DELAY_RST;
         trl_d = 1'b0;
         pas_d = 1'b0;
      end
   end
   always_ff @(posedge i_clk) begin
      dly_q <= dly_d;
      trl_q <= trl_d;
      pas_q <= pas_d;
      qt_q  <= qt_d;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);
   property p_rst; $fell(i_reset) |-> o_mgmt_clk_sel == 2'h1; endproperty
   a_rst: assert property (p_rst) else $error("clock select reset");
   property p_sel; i_req.wr && i_req.addr == SGP_OFS_MGMT_TRAILER
      |=> o_mgmt_clk_sel == $past(i_req.wdata[5:4]); endproperty
   a_sel: assert property (p_sel) else $error("clock select");
   property p_trl;
      o_trailer_insert == (trl_q && i_egress_port == 3'h5);
   endproperty
   a_trl: assert property (p_trl) else $error("trailer port");
   property p_pau; o_pause_drop == (i_pause_frame && !pas_q); endproperty
   a_pau: assert property (p_pau) else $error("pause drop");
   property p_pll; o_pll_power_down |-> o_power_mode == 2'h1; endproperty
   a_pll: assert property (p_pll) else $error("pll mode");
   property p_rdc; i_req.rd && !i_req.wr && i_req.addr == SGP_OFS_POWER_DOWN
      |=> o_reg_rvalid && o_reg_rdata[4:3] == $past(o_power_mode)
      && o_power_mode == 2'h0; endproperty
   a_rdc: assert property (p_rdc) else $error("read clear");
   property p_ear; $rose(o_low_power) |-> qt_q >= dly_q * UNIT_CYCLES;
   endproperty
   a_ear: assert property (p_ear) else $error("sleep too early");
   property p_lat; qt_q > dly_q * UNIT_CYCLES + UNIT_CYCLES + 8
      |-> o_low_power; endproperty
   a_lat: assert property (p_lat) else $error("sleep too late");
   c_low: cover property ($rose(o_low_power));
   c_rdc: cover property (i_req.rd && o_power_mode != 2'h0);
   c_trl: cover property (o_trailer_insert);
endmodule
bind sgp_regs sgp_regs_chk #(.UNIT_CYCLES(UNIT_CYCLES)) sgp_regs_chk_i (
   .i_clk, .i_reset, .i_req, .o_reg_rdata, .o_reg_rvalid, .i_egress_port,
   .i_pause_frame, .i_energy_detected, .o_mgmt_clk_sel, .o_trailer_insert,
   .o_pause_drop, .o_power_mode, .o_pll_power_down, .o_low_power);
`default_nettype wire

// ---- test/sgp_host.sv ----
// sgp_host: management host model issuing register requests
`timescale 1ns/1ns
`default_nettype none
module sgp_host
   import sgp_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic [7:0] i_rdata,
   input  wire logic       i_rvalid,
   output sgp_reg_req_t    o_req
);
   initial o_req = '0;
   // one access: strobe for one edge, data taken after it
   task automatic xfer(input logic [7:0] a, input logic w,
                       input logic [7:0] d, output logic [7:0] q);
      @(negedge i_clk);
      o_req = {a, w, !w, d};
      @(negedge i_clk);
      o_req = '0;
      // data only counts while the valid pulse stands
      q = i_rvalid ? i_rdata : 8'hxx;
   endtask
endmodule
`default_nettype wire

// ---- test/sgp_regs_test.sv ----
// sgp_regs_test: register bank testbench
`timescale 1ns/1ns
`default_nettype none
module sgp_regs_test
   import sgp_pkg::*;
;
   logic            i_clk = 1'b0;
   logic            i_reset = 1'b1;
   sgp_reg_req_t    i_req;
   logic [7:0]      o_reg_rdata, b;
   logic [2:0]      i_egress_port = 3'h0;
   logic            i_pause_frame = 1'b0;
   logic            i_energy_detected = 1'b1;
   sgp_mgmt_clk_t   o_mgmt_clk_sel;
   logic            o_trailer_insert, o_pause_drop;
   logic            o_pll_power_down, o_low_power;
   logic            o_reg_rvalid;
   sgp_power_mode_t o_power_mode;
   int              checks = 0;
   int              fail_count = 0;
   always #50 i_clk = ~i_clk;
   sgp_regs #(.UNIT_CYCLES(4)) sgp_regs_i (.i_clk, .i_reset, .i_req,
      .o_reg_rdata, .o_reg_rvalid, .i_egress_port, .i_pause_frame,
      .i_energy_detected, .o_mgmt_clk_sel, .o_trailer_insert, .o_pause_drop,
      .o_power_mode, .o_pll_power_down, .o_low_power);
   sgp_host sgp_host_i (.i_clk, .i_rdata(o_reg_rdata),
      .i_rvalid(o_reg_rvalid), .o_req(i_req));
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp1(input logic got, input logic exp);
      cmp({7'h0, got}, {7'h0, exp});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      sgp_host_i.xfer(a, 1'b1, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      sgp_host_i.xfer(a, 1'b0, 8'h00, q);
      cmp(q, exp);
   endtask
   task automatic end_sim;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #500_000;
      fail_count++;
      $display("Error at %0t: watchdog expired", $time);
      end_sim();
   end
   initial begin
      repeat (20) @(negedge i_clk);
      i_reset = 1'b0;
      rd(SGP_OFS_MGMT_TRAILER, 8'h54);
      rd(SGP_OFS_POWER_DOWN, 8'h00);
      rd(SGP_OFS_SLEEP_DELAY, 8'h50);
      wr(8'h20, 8'hff);
      rd(8'h20, 8'h00);
      rd(SGP_OFS_FACTORY_TEST, 8'h00);
      i_pause_frame = 1'b1;
      for (int v = 0; v < 3; v++) begin
         b = {2'h0, v[1:0], 2'h0, v != 1, v[0]};
         wr(SGP_OFS_MGMT_TRAILER, b);
         cmp({6'h0, o_mgmt_clk_sel}, {6'h0, v[1:0]});
         rd(SGP_OFS_MGMT_TRAILER, b | 8'h44);
         cmp({7'h0, o_pause_drop}, {7'h0, !v[0]});
         for (int p = 0; p < 8; p++) begin
            i_egress_port = p[2:0];
            @(negedge i_clk);
            cmp1(o_trailer_insert, v != 1 && p == 5);
         end
      end
      for (int m = 0; m < 3; m++) begin
         b = {3'h1, m[1:0], 3'h0};
         wr(SGP_OFS_POWER_DOWN, b);
         cmp({6'h0, o_power_mode}, {6'h0, m[1:0]});
         cmp({7'h0, o_pll_power_down}, {7'h0, m == 1});
         rd(SGP_OFS_POWER_DOWN, b);
         cmp({6'h0, o_power_mode}, 8'h00);
         rd(SGP_OFS_POWER_DOWN, 8'h20);
      end
      wr(SGP_OFS_SLEEP_DELAY, 8'h02);
      wr(SGP_OFS_POWER_DOWN, 8'h08);
      i_energy_detected = 1'b0;
      repeat (6) @(negedge i_clk);
      i_energy_detected = 1'b1;
      repeat (3) @(negedge i_clk);
      i_energy_detected = 1'b0;
      repeat (7) @(negedge i_clk);
      cmp({7'h0, o_low_power}, 8'h00);
      for (int n = 0; n < 20 && o_low_power !== 1'b1; n++)
         @(negedge i_clk);
      cmp({7'h0, o_low_power}, 8'h01);
      repeat (12) @(negedge i_clk);
      cmp1(o_low_power, 1'b1);
      rd(SGP_OFS_POWER_DOWN, 8'h08);
      @(negedge i_clk);
      cmp({7'h0, o_low_power}, 8'h00);
      // mid-run reset must restore the written fields
      i_reset = 1'b1;
      repeat (2) @(negedge i_clk);
      i_reset = 1'b0;
      rd(SGP_OFS_SLEEP_DELAY, 8'h50);
      rd(SGP_OFS_MGMT_TRAILER, 8'h54);
      end_sim();
   end
endmodule
`default_nettype wire
